// File: common/safety_timer_thermistor_params.svh
// constants for the safety timer and thermistor monitor register
`ifndef SAFETY_TIMER_THERMISTOR_PARAMS_SVH
`define SAFETY_TIMER_THERMISTOR_PARAMS_SVH

// ----------------------------------------------------------------------------
// register location and layout
// ----------------------------------------------------------------------------
`define STT_REG_ADDR        8'h07
`define STT_RESET_IMAGE     8'h98
`define STT_BIT_SLOWDOWN    7
`define STT_BIT_LIMIT_HI    6
`define STT_BIT_LIMIT_LO    5
`define STT_BIT_SPARE       4
`define STT_BIT_MON_EN      3
`define STT_BIT_FAULT_HI    2
`define STT_BIT_FAULT_LO    1
`define STT_BIT_HALF_CUR    0

// ----------------------------------------------------------------------------
// timing: clock period and safety timer tick, both in ns
// ----------------------------------------------------------------------------
`define STT_CLK_PERIOD_NS   5
`define STT_TICK_PERIOD_NS  1000000000
`define STT_TICK_CYCLES     (`STT_TICK_PERIOD_NS / `STT_CLK_PERIOD_NS)

// fast-charge limits in minutes, converted to one-second ticks
`define STT_LIMIT_SHORT_MIN 27
`define STT_LIMIT_MID_MIN   360
`define STT_LIMIT_LONG_MIN  540
`define STT_SEC_PER_MIN     60

// ----------------------------------------------------------------------------
// charge current scale in mA
// ----------------------------------------------------------------------------
`define STT_CUR_OFFSET_MA   12'd550
`define STT_CUR_STEP_MA     12'd75

`endif

// File: common/safety_timer_thermistor_pkg.sv
// types shared by the safety timer and thermistor monitor register
package safety_timer_thermistor_pkg;

   // limit select codes
   typedef enum logic [1:0] {
      LIMIT_27_MIN = 2'b00,
      LIMIT_6_HOUR = 2'b01,
      LIMIT_9_HOUR = 2'b10,
      LIMIT_OFF    = 2'b11
   } limit_sel_t;

   // temperature fault codes
   typedef enum logic [1:0] {
      FAULT_NONE     = 2'b00,
      FAULT_COLD_HOT = 2'b01,
      FAULT_COOL     = 2'b10,
      FAULT_WARM     = 2'b11
   } temp_fault_t;

   // regulation loops that slow the timer
   typedef struct packed {
      logic input_current_limit;
      logic input_voltage_droop_regulation;
      logic thermal_regulation;
      logic battery_short_condition;
   } slow_cond_t;

   // thermistor comparator levels
   typedef struct packed {
      logic below_cold_threshold;
      logic below_cool_threshold;
      logic above_warm_threshold;
      logic above_hot_threshold;
   } temp_cmp_t;

endpackage : safety_timer_thermistor_pkg

// File: logic/safety_timer_thermistor_reg.sv
// safety timer and thermistor monitor control/status register
`timescale 1ns/100ps
`default_nettype none
`include "safety_timer_thermistor_params.svh"

module safety_timer_thermistor_reg #(
   parameter int unsigned TICK_CYCLES  = `STT_TICK_CYCLES,
   parameter bit          COOL_SUPPORT = 1'b1,
   parameter bit          WARM_SUPPORT = 1'b1
) (
   // clock, reset, enable
   input  wire logic                                clk_i,
   input  wire logic                                rstn_i,
   input  wire logic                                ce_i,
   // register access from the serial interface
   input  wire logic [7:0]                          reg_addr_i,
   input  wire logic                                wr_en_i,
   input  wire logic                                rd_en_i,
   input  wire logic [7:0]                          wdata_i,
   output logic      [7:0]                          rdata_o,
   // charger state, same clock
   input  wire logic                                charge_active_i,
   input  wire logic [4:0]                          charge_field_i,
   // analog status, asynchronous
   input  wire safety_timer_thermistor_pkg::slow_cond_t cond_i,
   input  wire safety_timer_thermistor_pkg::temp_cmp_t  temp_i,
   // control outputs
   output logic      [11:0]                         charge_current_ma_o,
   output logic                                     charge_suspend_o,
   output logic                                     voltage_reduce_o,
   output logic                                     timer_expired_o,
   output logic      [1:0]                          temp_fault_code_o
);

   // ----------------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------------
   if (TICK_CYCLES < 2) begin : g_bad_tick
      $error("TICK_CYCLES must be at least 2");
   end

   localparam int unsigned SEC_SHORT = `STT_LIMIT_SHORT_MIN * `STT_SEC_PER_MIN;
   localparam int unsigned SEC_MID   = `STT_LIMIT_MID_MIN * `STT_SEC_PER_MIN;
   localparam int unsigned SEC_LONG  = `STT_LIMIT_LONG_MIN * `STT_SEC_PER_MIN;
   // named copy of the reset image so single bits can be selected from it
   localparam logic [7:0]  RESET_IMAGE = `STT_RESET_IMAGE;

   // ----------------------------------------------------------------------
   // register bits, address match and read image
   // ----------------------------------------------------------------------
   logic                                      timer_slowdown_enable;
   safety_timer_thermistor_pkg::limit_sel_t   limit_sel;
   logic                                      spare_bit;
   logic                                      thermistor_monitor_enable;
   logic                                      half_current_select;
   safety_timer_thermistor_pkg::temp_fault_t  temp_fault;
   logic                                      hit;
   logic [7:0]                                image;

   assign hit = (reg_addr_i == `STT_REG_ADDR);

   // write port; fault bits are loaded only by the classifier so writes to them fall away
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         timer_slowdown_enable     <= RESET_IMAGE[`STT_BIT_SLOWDOWN];
         limit_sel                 <= safety_timer_thermistor_pkg::limit_sel_t'(
            RESET_IMAGE[`STT_BIT_LIMIT_HI:`STT_BIT_LIMIT_LO]);
         spare_bit                 <= RESET_IMAGE[`STT_BIT_SPARE];
         thermistor_monitor_enable <= RESET_IMAGE[`STT_BIT_MON_EN];
         half_current_select       <= RESET_IMAGE[`STT_BIT_HALF_CUR];
      end else if (ce_i && wr_en_i && hit) begin
         timer_slowdown_enable     <= wdata_i[`STT_BIT_SLOWDOWN];
         limit_sel                 <= safety_timer_thermistor_pkg::limit_sel_t'(
            wdata_i[`STT_BIT_LIMIT_HI:`STT_BIT_LIMIT_LO]);
         spare_bit                 <= wdata_i[`STT_BIT_SPARE];
         thermistor_monitor_enable <= wdata_i[`STT_BIT_MON_EN];
         half_current_select       <= wdata_i[`STT_BIT_HALF_CUR];
      end
   end

   // read image: stored bits plus live fault code
   always_comb begin
      image                                       = 8'h00;
      image[`STT_BIT_SLOWDOWN]                    = timer_slowdown_enable;
      image[`STT_BIT_LIMIT_HI:`STT_BIT_LIMIT_LO]  = limit_sel;
      image[`STT_BIT_SPARE]                       = spare_bit;
      image[`STT_BIT_MON_EN]                      = thermistor_monitor_enable;
      image[`STT_BIT_FAULT_HI:`STT_BIT_FAULT_LO]  = temp_fault;
      image[`STT_BIT_HALF_CUR]                    = half_current_select;
   end

   // read data held until the next read; other addresses answer zero
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rdata_o <= 8'h00;
      end else if (ce_i && rd_en_i) begin
         rdata_o <= hit ? image : 8'h00;
      end
   end

   // ----------------------------------------------------------------------
   // synchronisers for the analog status levels
   // ----------------------------------------------------------------------
   logic [7:0] sync_meta;
   logic [7:0] sync_q;
   safety_timer_thermistor_pkg::slow_cond_t cond_s;
   safety_timer_thermistor_pkg::temp_cmp_t  temp_s;

   // two stages; only the second stage feeds any logic
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sync_meta <= 8'h00;
         sync_q    <= 8'h00;
      end else if (ce_i) begin
         sync_meta <= {cond_i, temp_i};
         sync_q    <= sync_meta;
      end
   end

   assign cond_s = sync_q[7:4];
   assign temp_s = sync_q[3:0];

   // ----------------------------------------------------------------------
   // temperature fault classification
   // ----------------------------------------------------------------------
   safety_timer_thermistor_pkg::temp_fault_t next_temp_fault;

   // out-of-range wins over the softer bands, so a glitchy cool/cold edge
   // never lets charging continue below the cold limit
   always_comb begin
      if (!thermistor_monitor_enable) begin
         next_temp_fault = safety_timer_thermistor_pkg::FAULT_NONE;
      end else if (temp_s.below_cold_threshold ||
                   temp_s.above_hot_threshold) begin
         next_temp_fault = safety_timer_thermistor_pkg::FAULT_COLD_HOT;
      end else if (temp_s.below_cool_threshold) begin
         next_temp_fault = safety_timer_thermistor_pkg::FAULT_COOL;
      end else if (temp_s.above_warm_threshold) begin
         next_temp_fault = safety_timer_thermistor_pkg::FAULT_WARM;
      end else begin
         next_temp_fault = safety_timer_thermistor_pkg::FAULT_NONE;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         temp_fault <= safety_timer_thermistor_pkg::FAULT_NONE;
      end else if (ce_i) begin
         temp_fault <= next_temp_fault;
      end
   end

   assign temp_fault_code_o = temp_fault;
   assign charge_suspend_o  =
      (temp_fault == safety_timer_thermistor_pkg::FAULT_COLD_HOT);
   assign voltage_reduce_o  = WARM_SUPPORT &&
      (temp_fault == safety_timer_thermistor_pkg::FAULT_WARM);

   // ----------------------------------------------------------------------
   // charge current
   // ----------------------------------------------------------------------
   logic        halve;
   logic [11:0] full_ma;

   assign halve = half_current_select || (COOL_SUPPORT &&
      temp_fault == safety_timer_thermistor_pkg::FAULT_COOL);
   assign full_ma = `STT_CUR_OFFSET_MA +
      12'(charge_field_i * `STT_CUR_STEP_MA);

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         charge_current_ma_o <= 12'h000;
      end else if (ce_i) begin
         charge_current_ma_o <= halve ? (full_ma >> 1) : full_ma;
      end
   end

   // ----------------------------------------------------------------------
   // fast-charge safety timer, one-second ticks
   // ----------------------------------------------------------------------
   logic [31:0] pre_cnt;
   logic        tick;
   logic        half_phase;
   logic        slowed;
   logic [15:0] elapsed;
   logic [15:0] limit_sec;

   assign tick = (pre_cnt == 32'(TICK_CYCLES - 1));

   // any qualifying condition halves the rate, only when enabled
   assign slowed = timer_slowdown_enable && (|cond_s || half_current_select
      || temp_fault == safety_timer_thermistor_pkg::FAULT_COOL);

   always_comb begin
      case (limit_sel)
         safety_timer_thermistor_pkg::LIMIT_27_MIN: limit_sec = 16'(SEC_SHORT);
         safety_timer_thermistor_pkg::LIMIT_6_HOUR: limit_sec = 16'(SEC_MID);
         safety_timer_thermistor_pkg::LIMIT_9_HOUR: limit_sec = 16'(SEC_LONG);
         default:                                   limit_sec = 16'hffff;
      endcase
   end

   // prescaler and phase run only while charging so each charge starts fresh
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pre_cnt    <= 32'h0;
         half_phase <= 1'b0;
         elapsed    <= 16'h0;
      end else if (ce_i) begin
         if (!charge_active_i) begin
            pre_cnt    <= 32'h0;
            half_phase <= 1'b0;
            elapsed    <= 16'h0;
         end else begin
            pre_cnt <= tick ? 32'h0 : pre_cnt + 32'h1;
            if (tick) begin
               half_phase <= slowed ? ~half_phase : 1'b0;
               if ((!slowed || half_phase) && elapsed != 16'hffff) begin
                  elapsed <= elapsed + 16'h1;
               end
            end
         end
      end
   end

   // expiry holds until charging stops; disabled code never expires
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         timer_expired_o <= 1'b0;
      end else if (ce_i) begin
         timer_expired_o <= charge_active_i &&
            limit_sel != safety_timer_thermistor_pkg::LIMIT_OFF &&
            elapsed >= limit_sec;
      end
   end

   // ----------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   AST_READ_MAP: assert property (
      ce_i && rd_en_i && hit |=> rdata_o == $past(image))
      else $error("read data does not match register image");
   AST_SLOW_WRITE: assert property (
      ce_i && wr_en_i && hit |=>
      timer_slowdown_enable == $past(wdata_i[`STT_BIT_SLOWDOWN]))
      else $error("slowdown bit not written");
   AST_HALF_RATE: assert property (
      ce_i && charge_active_i && tick && slowed && !half_phase
      |=> elapsed == $past(elapsed))
      else $error("timer advanced on skipped half-rate tick");
   AST_LIMIT_OFF: assert property (
      limit_sel == safety_timer_thermistor_pkg::LIMIT_OFF ##1
      limit_sel == safety_timer_thermistor_pkg::LIMIT_OFF |-> !timer_expired_o)
      else $error("timer expired while disabled");
   AST_MON_OFF: assert property (
      ce_i && !thermistor_monitor_enable |=> temp_fault_code_o == 2'b00)
      else $error("fault reported with monitoring off");
   AST_SUSPEND: assert property (
      ce_i && thermistor_monitor_enable && temp_s.below_cold_threshold
      |=> charge_suspend_o)
      else $error("cold did not suspend charging");
   AST_WARM: assert property (
      voltage_reduce_o |-> temp_fault_code_o == 2'b11 && WARM_SUPPORT)
      else $error("voltage reduced outside warm band");
   AST_HALF_CUR: assert property (
      ce_i && half_current_select |=>
      charge_current_ma_o == ($past(full_ma) >> 1))
      else $error("half current not applied");
   AST_FAULT_RO: assert property (
      ce_i && wr_en_i && hit |=> temp_fault == $past(next_temp_fault))
      else $error("write disturbed fault code");

   COV_EXPIRE: cover property ($rose(timer_expired_o));
   COV_COOL:   cover property (temp_fault_code_o == 2'b10 && halve);
   COV_SLOWED: cover property (tick && slowed && charge_active_i);

endmodule : safety_timer_thermistor_reg
`default_nettype wire

// File: verification/host_model.sv
// host model that reads and writes the charger register over the byte port
`timescale 1ns/100ps
`default_nettype none

module host_model (
   // clock
   input  wire logic       clk_i,
   // register port towards the device
   output logic      [7:0] reg_addr_o,
   output logic            wr_en_o,
   output logic            rd_en_o,
   output logic      [7:0] wdata_o,
   input  wire logic [7:0] rdata_i
);
   // ------------------------------------------------------------------------
   // access tasks
   // ------------------------------------------------------------------------
   // idle state at time zero, strobes low
   initial begin
      reg_addr_o = 8'h00;
      wr_en_o    = 1'b0;
      rd_en_o    = 1'b0;
      wdata_o    = 8'h00;
   end

   // one-cycle write strobe; data inverted afterwards so nothing leans on it
   task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
      @(posedge clk_i);
      #1;
      reg_addr_o = addr;
      wdata_o    = data;
      wr_en_o    = 1'b1;
      @(posedge clk_i);
      #1;
      wr_en_o = 1'b0;
      wdata_o = ~data;
   endtask : write_reg

   // read data is taken 1 ns after the same edge that samples the strobe
   task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
      @(posedge clk_i);
      #1;
      reg_addr_o = addr;
      rd_en_o    = 1'b1;
      @(posedge clk_i);
      #1;
      rd_en_o = 1'b0;
      data    = rdata_i;
   endtask : read_reg
endmodule : host_model

`default_nettype wire

// File: verification/safety_timer_thermistor_reg_test.sv
// self-checking bench for the safety timer and thermistor register
`timescale 1ns/100ps
`default_nettype none

module safety_timer_thermistor_reg_test;
   // ------------------------------------------------------------------------
   // signals
   // ------------------------------------------------------------------------
   localparam int unsigned TICKS = 4;
   localparam logic [11:0] FULL  = 12'd550 + 12'd75 * 12'd6;
   typedef struct {
      logic [3:0]  temp;
      logic [1:0]  fault;
   } row_t;
   logic                                     clk_i;
   logic                                     rstn_i;
   logic                                     ce_i;
   logic                                     charge_active_i;
   logic                               [4:0] charge_field_i;
   safety_timer_thermistor_pkg::slow_cond_t  cond_i;
   safety_timer_thermistor_pkg::temp_cmp_t   temp_i;
   logic                               [7:0] reg_addr, wdata, rdata, rd;
   logic                                     wr_en, rd_en;
   logic                              [11:0] cur;
   logic                                     susp, vred, expired;
   logic                               [1:0] fault;
   int                                       bad_count;
   int                                       num_checks;
   row_t                                     rows[5];

   safety_timer_thermistor_reg #(.TICK_CYCLES(TICKS))
      i_safety_timer_thermistor_reg (
      .clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .reg_addr_i(reg_addr),
      .wr_en_i(wr_en), .rd_en_i(rd_en), .wdata_i(wdata), .rdata_o(rdata),
      .charge_active_i(charge_active_i), .charge_field_i(charge_field_i),
      .cond_i(cond_i), .temp_i(temp_i), .charge_current_ma_o(cur),
      .charge_suspend_o(susp), .voltage_reduce_o(vred),
      .timer_expired_o(expired), .temp_fault_code_o(fault));

   host_model i_host_model (
      .clk_i(clk_i), .reg_addr_o(reg_addr), .wr_en_o(wr_en),
      .rd_en_o(rd_en), .wdata_o(wdata), .rdata_i(rdata));

   // clock at 200 MHz
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   // ------------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------------
   task automatic check(input string name, input logic [11:0] exp,
                        input logic [11:0] got);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : conclude

   // counts cycles to expiry; exp of zero means it must never expire
   // slow carries the regulation loops that are active during the run
   task automatic run_timer(input logic [7:0] val, input logic [3:0] slow,
                            input int exp);
      int n;
      n = 0;
      cond_i = slow;
      i_host_model.write_reg(8'h07, val);
      @(posedge clk_i);
      #1 charge_active_i = 1'b1;
      while (expired !== 1'b1 && n < 14000) begin
         @(posedge clk_i);
         #1 n++;
      end
      if (exp == 0) check("never expires", 12'h001, 12'(n >= 14000));
      else check("expiry window", 12'h001, 12'(n > exp - 8 && n < exp + 8));
      charge_active_i = 1'b0;
      repeat (2) @(posedge clk_i);
      #1 check("expired cleared", 12'h000, {11'h000, expired});
      cond_i = '0;
      $display("timer run for %h done", val);
   endtask : run_timer

   // hang guard, well past the longest expected run
   initial begin
      #(90000 * 5);
      bad_count++;
      $display("FAIL watchdog expected done seen hang");
      conclude();
   end

   // ------------------------------------------------------------------------
   // tests
   // ------------------------------------------------------------------------
   initial begin
      bad_count = 0;
      num_checks = 0;
      rstn_i = 1'b0;
      ce_i = 1'b1;
      charge_active_i = 1'b0;
      charge_field_i = 5'h06;
      cond_i = '0;
      temp_i = '0;
      rows[0] = '{4'b0000, 2'b00};
      rows[1] = '{4'b1100, 2'b01};
      rows[2] = '{4'b0011, 2'b01};
      rows[3] = '{4'b0100, 2'b10};
      rows[4] = '{4'b0010, 2'b11};
      repeat (4) @(posedge clk_i);
      #1 rstn_i = 1'b1;
      // temperature bands against the live code, flags and current
      foreach (rows[i]) begin
         temp_i = rows[i].temp;
         repeat (5) @(posedge clk_i);
         #1 check("fault code", {10'h0, rows[i].fault}, {10'h0, fault});
         check("suspend", {11'h0, rows[i].fault == 2'b01}, {11'h0, susp});
         check("reduce", {11'h0, rows[i].fault == 2'b11}, {11'h0, vred});
         if (rows[i].fault != 2'b01)
            check("band current", rows[i].fault == 2'b10 ? FULL >> 1 : FULL, cur);
         i_host_model.read_reg(8'h07, rd);
         check("fault bits", {10'h0, rows[i].fault}, {10'h0, rd[2:1]});
      end
      temp_i = '0;
      $display("temperature table done");
      // reset image and register access
      i_host_model.write_reg(8'h07, 8'hff);
      i_host_model.read_reg(8'h07, rd);
      check("write all ones", 12'h0f9, {4'h0, rd});
      i_host_model.write_reg(8'h06, 8'h00);
      i_host_model.read_reg(8'h07, rd);
      check("other address write", 12'h0f9, {4'h0, rd});
      i_host_model.read_reg(8'h06, rd);
      check("other address read", 12'h000, {4'h0, rd});
      ce_i = 1'b0;
      i_host_model.write_reg(8'h07, 8'h00);
      ce_i = 1'b1;
      i_host_model.read_reg(8'h07, rd);
      check("frozen write", 12'h0f9, {4'h0, rd});
      rstn_i = 1'b0;
      @(posedge clk_i);
      #1 rstn_i = 1'b1;
      i_host_model.read_reg(8'h07, rd);
      check("reset image", 12'h098, {4'h0, rd});
      check("full current", FULL, cur);
      $display("register access done");
      // half current and monitor disable
      i_host_model.write_reg(8'h07, 8'h99);
      repeat (2) @(posedge clk_i);
      #1 check("half current", FULL >> 1, cur);
      i_host_model.write_reg(8'h07, 8'h90);
      temp_i = 4'b1100;
      repeat (5) @(posedge clk_i);
      #1 check("monitor off code", 12'h000, {10'h0, fault});
      check("monitor off suspend", 12'h000, {11'h0, susp});
      check("restored current", FULL, cur);
      temp_i = '0;
      $display("half current and monitor done");
      // safety timer limits and slowdown
      run_timer(8'h98, 4'h0, 1620 * TICKS);
      run_timer(8'h98, 4'h2, 3240 * TICKS);
      run_timer(8'h98, 4'hd, 3240 * TICKS);
      run_timer(8'h18, 4'h2, 1620 * TICKS);
      run_timer(8'h99, 4'h0, 3240 * TICKS);
      run_timer(8'hf8, 4'h0, 0);
      conclude();
   end
endmodule : safety_timer_thermistor_reg_test

`default_nettype wire
